// >>> rtl/adc_ctrl_consts.vh
// Timing constants for the converter sampling controller.
// Assumes a 250 MHz system clock (4 ns period); included by bare name.
`ifndef ADC_CTRL_CONSTS_VH
`define ADC_CTRL_CONSTS_VH

`define CLK_PERIOD_NS        4
// Encode pulse least width and least gap before the next period ends
`define ENC_MIN_WIDTH_NS     50
`define ENC_END_MARGIN_NS    350
// Least delay from encode leading edge to strobe leading edge
`define STROBE_DELAY_NS      950
// Least strobe width
`define STROBE_WIDTH_NS      50
// Settle time for floating outputs before the word is sampled
`define SETTLE_NS            100
// Least encode period: strobe delay, strobe width, settle and hand-off
// must all finish before the next encode, or that encode is missed
`define MIN_PERIOD_NS        1200
// Cycle counts derived from the figures (least times round up)
`define ENC_MIN_WIDTH_CYC  ((`ENC_MIN_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ENC_END_MARGIN_CYC ((`ENC_END_MARGIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_DELAY_CYC   ((`STROBE_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_WIDTH_CYC   ((`STROBE_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_CYC         ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MIN_PERIOD_CYC     ((`MIN_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Converter word width
`define DATA_W               12
// Default encode period in cycles (arbitrary, 2 us)
`define DEF_PERIOD_CYC       500

`endif

// >>> rtl/skid_buf2.v
// Two-entry buffer with valid/ready on both sides.
// Assumes one clock, synchronous active-high reset, clock enable.
`timescale 1ns/10ps
module skid_buf2 #(
    parameter WIDTH = 12
) (
    input  wire             clk_sys,
    input  wire             srst,
    input  wire             ce,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:1];
    reg             wr_ptr;
    reg             rd_ptr;
    reg [1:0]       count;
    wire            push;
    wire            pop;

    // Full and empty follow the entry count directly
    assign in_ready  = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Pointers and count; a push and a pop together keep the count
    always @(posedge clk_sys) begin
        if (srst) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end else if (ce) begin
            if (push) begin
                mem[wr_ptr] <= in_data;
                wr_ptr      <= ~wr_ptr;
            end
            if (pop)
                rd_ptr <= ~rd_ptr;
            if (push && !pop)
                count <= count + 2'h1;
            else if (pop && !push)
                count <= count - 2'h1;
        end
    end
endmodule

// >>> rtl/adc_sample_ctrl.v
// Host controller that drives a 12-bit pipelined converter by its pins.
// Assumes the converter data pins arrive asynchronously and are pulled
// high when floating; encode, strobe and enable go straight to pins.
//
// Function
// [RULE1] Each encode pulse lasts at least 50 ns and ends at least 350 ns before the period ends.
// [RULE2] A square-wave encode is acceptable, so a half-period pulse is always legal.
// [RULE3] The converter holds about 670 ns after encode, then tracks for the rest of the period.
// [RULE4] For 50 ns after encode the converter still shows the previous result.
// [RULE5] A strobe leading edge comes at least 950 ns after the encode it captures.
// [RULE6] The output word stays stable until the next strobe while enable is low.
// [RULE7] Enable high floats the data pins; enable low drives them.
// [RULE8] With encode tied to strobe at up to 1.05 MHz each encode latches the previous result.
// [RULE9] Data validity is known only from the host's own encode and strobe timing.
// [RULE10] The strobe is derived from each encode by a delay of 950 ns up to the shortest period.
// [RULE11] The converter delivers a 12-bit word for the input at the encode instant.
// [RULE12] Full negative input gives all ones; further overrange floats the outputs.
// [RULE13] In negative overrange the inverted top bit is pulled low and stays low.
// [RULE14] Floating outputs get up to 100 ns to settle high before sampling.
// [RULE15] With no shared bus the enable is held low permanently; the code drives it high during reset.
// [RULE16] A word is captured only after its strobe and tagged with its encode number.
`timescale 1ns/10ps
`include "adc_ctrl_consts.vh"
module adc_sample_ctrl #(
    parameter DATA_W     = `DATA_W,
    parameter TAG_W      = 8,
    parameter CNT_W      = 16,
    parameter MIN_PERIOD = `MIN_PERIOD_CYC
) (
    input  wire              clk_sys,
    input  wire              srst,
    input  wire              ce,
    input  wire              run,
    input  wire [CNT_W-1:0]  period_cyc,
    input  wire              bus_shared,
    input  wire [DATA_W-1:0] adc_data_in,
    output reg               adc_encode,
    output reg               adc_strobe,
    output reg               adc_enable_n,
    output reg  [DATA_W-1:0] sample_data,
    output reg  [TAG_W-1:0]  sample_tag,
    output reg               sample_overrange,
    output reg               sample_valid,
    input  wire              sample_ready,
    output reg               overflow
);
    localparam [CNT_W-1:0] ENC_W   = `ENC_MIN_WIDTH_CYC;
    localparam [CNT_W-1:0] ENC_GAP = `ENC_END_MARGIN_CYC;
    localparam [CNT_W-1:0] STB_DLY = `STROBE_DELAY_CYC;
    localparam [CNT_W-1:0] STB_W   = `STROBE_WIDTH_CYC;
    localparam [CNT_W-1:0] SETTLE  = `SETTLE_CYC;
    localparam [CNT_W-1:0] MIN_P   = MIN_PERIOD;

    // Capture sequencer states
    localparam [1:0] CAP_IDLE   = 2'h0;
    localparam [1:0] CAP_STROBE = 2'h1;
    localparam [1:0] CAP_SETTLE = 2'h2;
    localparam [1:0] CAP_PUSH   = 2'h3;

    reg  [CNT_W-1:0]  per_cnt;
    reg  [CNT_W-1:0]  per_len;
    reg  [CNT_W-1:0]  enc_len;
    reg  [CNT_W-1:0]  cap_cnt;
    reg  [1:0]        cap_state;
    reg  [TAG_W-1:0]  enc_tag;
    reg  [TAG_W-1:0]  cap_tag;
    reg  [DATA_W-1:0] sync1;
    reg  [DATA_W-1:0] sync2;
    reg  [DATA_W-1:0] sync3;
    reg  [DATA_W-1:0] held;
    reg  [DATA_W+TAG_W:0] buf_in;
    reg               buf_in_valid;
    reg  [CNT_W-1:0]  next_per_len;
    reg  [CNT_W-1:0]  next_enc_len;
    wire              buf_in_ready;
    wire [DATA_W+TAG_W:0] buf_out;
    wire              ovr_pat;
    wire              buf_out_valid;
    wire              buf_out_ready;
    wire              per_end;
    wire              enc_start;

    // Clamp the period so a strobe and its width fit in every period;
    // encode width is half the period, a square wave, capped so it ends
    // 350 ns early and never under 50 ns
    always @* begin
        next_per_len = (period_cyc < MIN_P) ? MIN_P : period_cyc;
        next_enc_len = next_per_len >> 1;                       // [RULE2]
        if (next_enc_len > next_per_len - ENC_GAP)
            next_enc_len = next_per_len - ENC_GAP;              // [RULE1]
        if (next_enc_len < ENC_W)
            next_enc_len = ENC_W;                               // [RULE1]
    end

    assign per_end   = (per_cnt == per_len - 1'b1);
    assign enc_start = run && (per_cnt == {CNT_W{1'b0}});
    // Overrange: all lower bits float high while the top bit is pulled low
    assign ovr_pat   = (held == {1'b0, {(DATA_W-1){1'b1}}});

    // Encode generator; period and width latch only at a period start
    always @(posedge clk_sys) begin
        if (srst) begin
            per_cnt    <= {CNT_W{1'b0}};
            per_len    <= MIN_P;
            enc_len    <= ENC_W;
            adc_encode <= 1'b0;
            enc_tag    <= {TAG_W{1'b0}};
        end else if (ce) begin
            if (per_cnt == {CNT_W{1'b0}} && !run) begin
                adc_encode <= 1'b0;
                per_len    <= next_per_len;
                enc_len    <= next_enc_len;
            end else begin
                if (enc_start) begin
                    adc_encode <= 1'b1;
                    enc_tag    <= enc_tag + 1'b1;
                end else if (per_cnt == enc_len) begin
                    adc_encode <= 1'b0;                         // [RULE1]
                end
                if (per_end) begin
                    per_cnt <= {CNT_W{1'b0}};
                    per_len <= next_per_len;
                    enc_len <= next_enc_len;
                end else begin
                    per_cnt <= per_cnt + 1'b1;
                end
            end
        end
    end

    // Enable is high in reset, then low unless the pins are shared on a bus
    always @(posedge clk_sys) begin
        if (srst)
            adc_enable_n <= 1'b1;
        else if (ce)
            adc_enable_n <= bus_shared && (cap_state != CAP_SETTLE)
                            && (cap_state != CAP_PUSH);         // [RULE7] [RULE15]
    end

    // Three-stage synchroniser on the data pins
    always @(posedge clk_sys) begin
        if (srst) begin
            sync1 <= {DATA_W{1'b1}};
            sync2 <= {DATA_W{1'b1}};
            sync3 <= {DATA_W{1'b1}};
            held  <= {DATA_W{1'b1}};
        end else if (ce) begin
            sync1 <= adc_data_in;
            sync2 <= sync1;
            sync3 <= sync2;
            if (sync2 == sync3)
                held <= sync3;
        end
    end

    // Strobe fires a fixed delay after each encode edge, which keeps the
    // capture time constant even when the encode rate wanders. The word
    // then gets a settle window so floating bits can rise before sampling
    always @(posedge clk_sys) begin
        if (srst) begin
            cap_state    <= CAP_IDLE;
            cap_cnt      <= {CNT_W{1'b0}};
            cap_tag      <= {TAG_W{1'b0}};
            adc_strobe   <= 1'b0;
            buf_in       <= {(DATA_W+TAG_W+1){1'b0}};
            buf_in_valid <= 1'b0;
            overflow     <= 1'b0;
        end else if (ce) begin
            if (buf_in_valid && buf_in_ready)
                buf_in_valid <= 1'b0;
            case (cap_state)
            CAP_IDLE: begin
                if (enc_start) begin
                    cap_cnt   <= {CNT_W{1'b0}};
                    cap_tag   <= enc_tag + 1'b1;                // [RULE16]
                    cap_state <= CAP_STROBE;
                end
            end
            CAP_STROBE: begin
                cap_cnt <= cap_cnt + 1'b1;
                // Encode rises on the same edge that this count starts, so
                // rising at STB_DLY gives STB_DLY plus one cycle spacing
                if (cap_cnt == STB_DLY)
                    adc_strobe <= 1'b1;                         // [RULE5] [RULE10]
                if (cap_cnt == STB_DLY + STB_W) begin
                    adc_strobe <= 1'b0;
                    cap_cnt    <= {CNT_W{1'b0}};
                    cap_state  <= CAP_SETTLE;
                end
            end
            CAP_SETTLE: begin
                cap_cnt <= cap_cnt + 1'b1;
                if (cap_cnt == SETTLE + 2'h3)                   // [RULE14]
                    cap_state <= CAP_PUSH;
            end
            CAP_PUSH: begin
                // A busy input stage drops the new word, keeping the old
                // one intact; the tag travels with its own word
                if (buf_in_valid && !buf_in_ready) begin
                    overflow <= 1'b1;
                end else begin
                    buf_in       <= {cap_tag, ovr_pat, held};   // [RULE12] [RULE13]
                    buf_in_valid <= 1'b1;                       // [RULE9] [RULE16]
                end
                cap_state <= CAP_IDLE;
            end
            default: cap_state <= CAP_IDLE;
            endcase
        end
    end

    skid_buf2 #(
        .WIDTH (DATA_W + TAG_W + 1)
    ) u_buf (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .ce        (ce),
        .in_data   (buf_in),
        .in_valid  (buf_in_valid),
        .in_ready  (buf_in_ready),
        .out_data  (buf_out),
        .out_valid (buf_out_valid),
        .out_ready (buf_out_ready)
    );

    assign buf_out_ready = !sample_valid || sample_ready;

    // Registered output stage; tag is the encode whose word was sampled
    always @(posedge clk_sys) begin
        if (srst) begin
            sample_valid     <= 1'b0;
            sample_data      <= {DATA_W{1'b0}};
            sample_overrange <= 1'b0;
            sample_tag       <= {TAG_W{1'b0}};
        end else if (ce) begin
            if (buf_out_ready) begin
                sample_valid <= buf_out_valid;
                if (buf_out_valid) begin
                    sample_data      <= buf_out[DATA_W-1:0];    // [RULE11]
                    sample_overrange <= buf_out[DATA_W];
                    sample_tag       <= buf_out[DATA_W+TAG_W:DATA_W+1]; // [RULE16]
                end
            end
        end
    end
endmodule

// >>> verification/adc_ctrl_props.sv
// Checker on the sampling controller ports: pin timing and hand-off.
// Bound to every controller instance; ce is assumed held high.
`timescale 1ns/10ps
module adc_ctrl_props #(
    parameter DATA_W     = 12,
    parameter TAG_W      = 8,
    parameter CNT_W      = 16,
    parameter MIN_PERIOD = 300
) (
    input wire              clk_sys,
    input wire              srst,
    input wire              ce,
    input wire              run,
    input wire [CNT_W-1:0]  period_cyc,
    input wire              bus_shared,
    input wire [DATA_W-1:0] adc_data_in,
    input wire              adc_encode,
    input wire              adc_strobe,
    input wire              adc_enable_n,
    input wire [DATA_W-1:0] sample_data,
    input wire [TAG_W-1:0]  sample_tag,
    input wire              sample_overrange,
    input wire              sample_valid,
    input wire              sample_ready,
    input wire              overflow
);
    reg [11:0] since;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    // Cycles since the last encode rise; saturates so reset looks old
    always @(posedge clk_sys) begin
        if (srst || $rose(adc_encode))
            since <= srst ? 12'hFFF : 12'h001;
        else
            since <= since + {11'h000, ~&since};
    end
    a_enc_width: assert property (
        $rose(adc_encode) |=> adc_encode[*8] ##1 adc_encode[*4])
        else $error("encode pulse too short");
    a_period_min: assert property (
        $rose(adc_encode) |-> since >= MIN_PERIOD)
        else $error("encode period below minimum");
    a_strobe_delay: assert property (
        $rose(adc_strobe) |-> since >= 12'h0EE && !adc_encode)
        else $error("strobe too early");
    a_strobe_due: assert property (
        $rose(adc_encode) |-> ##[238:249] $rose(adc_strobe))
        else $error("strobe missing after encode");
    a_enable_low: assert property (
        !bus_shared && !$past(bus_shared) && !$past(srst) |-> !adc_enable_n)
        else $error("enable not held low");
    a_ovr_flag: assert property (
        sample_valid |-> sample_overrange == (sample_data == 12'h7FF))
        else $error("overrange flag wrong");
    a_valid_hold: assert property (
        sample_valid && !sample_ready |=> sample_valid && $stable(sample_tag)
        && $stable(sample_data)) else $error("held sample changed");
    a_settle: assert property (
        $fell(adc_strobe) |-> ##[25:150] sample_valid)
        else $error("no sample after strobe");
    // Main scenarios: words delivered, overrange seen, word dropped
    c_word: cover property ($rose(sample_valid));
    c_over: cover property (sample_valid && sample_overrange);
    c_drop: cover property ($rose(overflow));
endmodule
bind adc_sample_ctrl adc_ctrl_props #(.DATA_W(DATA_W), .TAG_W(TAG_W),
    .CNT_W(CNT_W), .MIN_PERIOD(MIN_PERIOD)) u_props (.clk_sys(clk_sys),
    .srst(srst), .ce(ce), .run(run), .period_cyc(period_cyc),
    .bus_shared(bus_shared), .adc_data_in(adc_data_in),
    .adc_encode(adc_encode), .adc_strobe(adc_strobe),
    .adc_enable_n(adc_enable_n), .sample_data(sample_data),
    .sample_tag(sample_tag), .sample_overrange(sample_overrange),
    .sample_valid(sample_valid), .sample_ready(sample_ready),
    .overflow(overflow));

// >>> verification/adc_conv_model.sv
// Behavioural converter: encode snapshot, pipelined result, output reg.
// Floating pins read high through the board pull-ups.
`timescale 1ns/10ps
module adc_conv_model (
    input  wire        adc_encode,
    input  wire        adc_strobe,
    input  wire        adc_enable_n,
    input  wire [11:0] vin,
    input  wire        vin_over,
    output wire [11:0] adc_data_in
);
    reg [11:0] res = 12'h000;
    reg [11:0] oreg = 12'h000;
    reg [11:0] snap;
    reg        rov = 1'b0;
    reg        oov = 1'b0;
    reg        sov;
    // Old result stays 50 ns, then reads inverted until the new one lands 900 ns after encode
    always @(posedge adc_encode) begin
        snap = vin;
        sov = vin_over;
        #50 res = ~res;
        #850 res = snap;
        rov = sov;
    end
    // Output register loads only on a strobe edge
    always @(posedge adc_strobe) begin
        oreg <= res;
        oov <= rov;
    end
    // Float reads as pull-up high; overrange reads high except the top bit held low
    assign adc_data_in = adc_enable_n ? 12'hFFF :
        (oov ? 12'h7FF : oreg);
endmodule

// >>> verification/adc_sample_ctrl_tb_top.sv
// Bench for the sampling controller against a converter model.
// One clock at 250 MHz; inputs change 1 ns after the rising edge.
`timescale 1ns/10ps
module adc_sample_ctrl_tb_top;
    reg         clk_sys = 1'b0;
    reg         srst = 1'b1;
    reg         run = 1'b0;
    reg  [15:0] period_cyc = 16'h0064;
    reg         bus_shared = 1'b0;
    reg         sample_ready = 1'b0;
    reg  [11:0] vin, w;
    reg  [7:0]  t, last;
    reg         vin_over, o;
    wire [11:0] adc_data_in, sample_data;
    wire [7:0]  sample_tag;
    wire        adc_encode, adc_strobe, adc_enable_n;
    wire        sample_overrange, sample_valid, overflow;
    integer     n_fail = 0, tests_run = 0, n_enc = 0, cyc = 0;
    adc_sample_ctrl DUT (.clk_sys(clk_sys), .srst(srst), .ce(1'b1),
        .run(run), .period_cyc(period_cyc), .bus_shared(bus_shared),
        .adc_data_in(adc_data_in), .adc_encode(adc_encode),
        .adc_strobe(adc_strobe), .adc_enable_n(adc_enable_n),
        .sample_data(sample_data), .sample_tag(sample_tag),
        .sample_overrange(sample_overrange), .sample_valid(sample_valid),
        .sample_ready(sample_ready), .overflow(overflow));
    adc_conv_model conv (.adc_encode(adc_encode), .adc_strobe(adc_strobe),
        .adc_enable_n(adc_enable_n), .vin(vin), .vin_over(vin_over),
        .adc_data_in(adc_data_in));
    // Word for encode k; every fifth encode is driven past full scale
    function [11:0] expw(input [11:0] k);
        expw = (k % 12'h005 == 12'h000) ? 12'h7FF : (k * 12'h0A3) ^ 12'h5A5;
    endfunction
    // New analog value once the encode edge has taken the old one
    always @(negedge adc_encode) begin
        n_enc = n_enc + 1;
        vin = expw(n_enc[11:0] + 12'h001);
        vin_over = (n_enc + 1) % 5 == 0;
    end
    initial forever #2 clk_sys = ~clk_sys;
    // Hang guard well above the planned run of about 5000 cycles
    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (cyc == 30000) begin
            n_fail = n_fail + 1;
            final_report;
        end
    end
    task chk(input string nm, input [11:0] e, input [11:0] g);
        begin
            tests_run = tests_run + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("unexpected %s exp %h got %h", nm, e, g);
            end
        end
    endtask
    // Take one word; ready stays up afterwards so nothing piles up
    task get;
        integer i;
        begin
            sample_ready = 1'b1;
            i = 0;
            while (sample_valid !== 1'b1 && i < 1500) begin
                @(posedge clk_sys) #1;
                i = i + 1;
            end
            {w, t, o} = {sample_data, sample_tag, sample_overrange};
            @(posedge clk_sys) #1;
            chk("wait", 12'h000, {11'h000, i == 1500});
            chk("data", expw({4'h0, t}), w);
            chk("ovr", {11'h000, w == 12'h7FF}, {11'h000, o});
        end
    endtask
    // Too short a period request is clamped; tags run 1 to 6 in order
    task t_stream;
        integer k;
        begin
            run = 1'b1;
            last = 8'h00;
            for (k = 0; k < 6; k = k + 1) begin
                get;
                chk("tag", {4'h0, last + 8'h01}, {4'h0, t});
                last = t;
            end
            $display("t_stream done");
        end
    endtask
    // Consumer stalls about seven periods: four words kept, later dropped
    task t_stall;
        integer k;
        begin
            sample_ready = 1'b0;
            repeat (2000) @(posedge clk_sys);
            #1 chk("ovf", 12'h001, {11'h000, overflow});
            get;
            last = t;
            get;
            chk("kept", {4'h0, last + 8'h01}, {4'h0, t});
            for (k = 0; k < 2; k = k + 1)
                get;
            $display("t_stall done");
        end
    endtask
    // Shared bus: pins float outside capture, yet words still arrive
    task t_shared;
        begin
            bus_shared = 1'b1;
            period_cyc = 16'h0190;
            get;
            get;
            @(posedge adc_encode) #41;
            chk("float", 12'h001, {11'h000, adc_enable_n});
            chk("pins", 12'hFFF, adc_data_in);
            get;
            get;
            $display("t_shared done");
        end
    endtask
    task final_report;
        begin
            $display("checks %0d mismatches %0d", tests_run, n_fail);
            if (n_fail == 0 && tests_run > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    initial begin
        vin = expw(12'h001);
        vin_over = 1'b0;
        repeat (4) @(posedge clk_sys);
        #1 srst = 1'b0;
        t_stream;
        t_stall;
        t_shared;
        final_report;
    end
endmodule
